// ### tcb_pkg.sv
// tcb_pkg: constants, types and helpers of the rffe register slave
// assumes: 8-bit registers reached by 5-bit or 8-bit rffe addresses
package tcb_pkg;
	localparam int REG_N = 14;
	localparam int SYNC_W = 5;
	localparam int SYNC_SCLK = 0;
	localparam int SYNC_SDATA = 1;
	localparam int SYNC_IO = 2;
	localparam int SYNC_FUSE = 3;

	localparam logic [7:0] OFF_ENABLE = 8'h00;
	localparam logic [7:0] OFF_OVERDRIVE = 8'h01;
	localparam logic [7:0] OFF_CODE_A = 8'h02;
	localparam logic [7:0] OFF_CODE_B = 8'h03;
	localparam logic [7:0] OFF_WAKEUP = 8'h09;
	localparam logic [7:0] OFF_BOOST = 8'h10;
	localparam logic [7:0] OFF_OD_STEPS = 8'h12;
	localparam logic [7:0] OFF_OD_MULT = 8'h13;
	localparam logic [7:0] OFF_STATUS = 8'h1A;
	localparam logic [7:0] OFF_GROUP_SID = 8'h1B;
	localparam logic [7:0] OFF_PMTRIG = 8'h1C;
	localparam logic [7:0] OFF_PRODUCT = 8'h1D;
	localparam logic [7:0] OFF_MAKER_LO = 8'h1E;
	localparam logic [7:0] OFF_SLAVE_ID_MAKER_CODE_HIGH = 8'h1F;
	localparam logic [7:0] OFF_GLIDE = 8'h2C;

	localparam logic [3:0] IDX_ENABLE = 4'h0;
	localparam logic [3:0] IDX_CODE_A = 4'h2;
	localparam logic [3:0] IDX_CODE_B = 4'h3;
	localparam logic [3:0] IDX_BOOST = 4'h5;
	localparam logic [3:0] IDX_STATUS = 4'h8;
	localparam logic [3:0] IDX_GROUP_SID = 4'h9;
	localparam logic [3:0] IDX_PMTRIG = 4'hA;
	localparam logic [3:0] IDX_PRODUCT = 4'hB;
	localparam logic [3:0] IDX_SLAVE_ID_MAKER_CODE_HIGH = 4'hC;

	localparam int ENA_SPREAD_POS = 6;
	localparam int ENA_A_POS = 3;
	localparam int ENA_B_POS = 2;
	localparam int PM_POS = 6;
	localparam int SWR_POS = 5;
	localparam int ERR_CMD_PAR = 0;
	localparam int ERR_DAT_PAR = 1;
	localparam int ERR_CMD = 2;
	localparam logic [1:0] PM_STARTUP = 2'h1;
	localparam logic [7:0] BOOST_FIXED = 8'h10;
	localparam logic [3:0] BROADCAST_SID = 4'h0;
	localparam logic [3:0] CMD_LAST = 4'hC;
	localparam logic [3:0] FRAME_LAST = 4'h8;
	localparam logic [3:0] TX_END = 4'h9;

	// identity values below are arbitrary
	localparam logic [9:0] MAKER_CODE = 10'h2A5;
	localparam logic [5:0] PRODUCT_HI = 6'h15;
	localparam logic [7:0] SLAVE_ID_MAKER_CODE_HIGH_DEFAULT = 8'h07;

	typedef logic [REG_N-1:0][7:0] tcb_regs_type;

	// index 13 down to 0: glide, slave_id_maker_code_high, product, pm, gsid, status,
	// od_mult, od_steps, boost, wakeup, code_b, code_a, overdrive, enable
	localparam tcb_regs_type REG_MASK = {8'h7F, 8'h0F, 8'h00, 8'hDF,
		8'h0F, 8'h07, 8'h0F, 8'h0F, 8'h0F, 8'h0C, 8'h7F, 8'h7F, 8'hFF,
		8'h4C};
	localparam tcb_regs_type REG_RESET = {8'h00, SLAVE_ID_MAKER_CODE_HIGH_DEFAULT, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h0B, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h40};

	typedef enum logic [2:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_TURN, ST_TX, ST_TXPARK
	} tcb_state_type;

	// bit 4 flags a mapped address, bits 3:0 give the storage index
	function automatic logic [4:0] tcb_index(input logic [7:0] addr);
		case (addr)
			OFF_ENABLE: return 5'h10;
			OFF_OVERDRIVE: return 5'h11;
			OFF_CODE_A: return 5'h12;
			OFF_CODE_B: return 5'h13;
			OFF_WAKEUP: return 5'h14;
			OFF_BOOST: return 5'h15;
			OFF_OD_STEPS: return 5'h16;
			OFF_OD_MULT: return 5'h17;
			OFF_STATUS: return 5'h18;
			OFF_GROUP_SID: return 5'h19;
			OFF_PMTRIG: return 5'h1A;
			OFF_PRODUCT: return 5'h1B;
			OFF_SLAVE_ID_MAKER_CODE_HIGH: return 5'h1C;
			OFF_GLIDE: return 5'h1D;
			default: return 5'h00;
		endcase
	endfunction

	// odd parity bit over up to twelve bits
	function automatic logic tcb_odd_par(input logic [11:0] v);
		return ~^v;
	endfunction
endpackage

// ### tcb_sync.sv
// tcb_sync: two-flop synchroniser for the link, supply and fuse pins
// assumes: inputs change with no relation to clk_in
`timescale 1ns/1ps
module tcb_sync (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [tcb_pkg::SYNC_W-1:0] async_in,
	output logic [tcb_pkg::SYNC_W-1:0] sync_out
);
	import tcb_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
	} tcb_sync_type;

	tcb_sync_type q;
	tcb_sync_type d;

	// first stage feeds the second stage only
	always_comb begin
		d.s1 = async_in;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '{s1: '0, s2: '0};
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.s2;
endmodule

// ### tcb_read_mux.sv
// tcb_read_mux: read-back value of one register address
// assumes: storage and fuse bits come from the clk_in domain
`timescale 1ns/1ps
module tcb_read_mux (
	input wire logic [7:0] addr_in,
	input wire tcb_pkg::tcb_regs_type regs_in,
	input wire logic [1:0] fuse_in,
	output logic [7:0] data_out
);
	import tcb_pkg::*;

	logic [4:0] hit;

	always_comb begin
		hit = tcb_index(addr_in);
		data_out = 8'h00;
		if (addr_in == OFF_MAKER_LO) begin
			data_out = MAKER_CODE[7:0];
		end else if (hit[4]) begin
			case (hit[3:0])
				IDX_PRODUCT: data_out = {PRODUCT_HI, fuse_in};
				IDX_SLAVE_ID_MAKER_CODE_HIGH: data_out = {2'b00, MAKER_CODE[9:8],
					regs_in[IDX_SLAVE_ID_MAKER_CODE_HIGH][3:0]};
				IDX_BOOST: data_out = regs_in[IDX_BOOST] | BOOST_FIXED;
				default: data_out = regs_in[hit[3:0]];
			endcase
		end
	end
endmodule

// ### tcb_rffe_slave.sv
// tcb_rffe_slave: rffe register slave of the two-output bias controller
// assumes: rffe link pins and io supply arrive asynchronously to clk_in,
// link clock well below a quarter of clk_in
`timescale 1ns/1ps
module tcb_rffe_slave (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic rffe_sclk_in,
	input wire logic rffe_sdata_in,
	output logic rffe_sdata_out,
	output logic rffe_sdata_oe_out,
	input wire logic io_supply_in,
	input wire logic [1:0] otp_fuse_in,
	output logic out_a_enable_out,
	output logic out_b_enable_out,
	output logic spread_enable_out,
	output logic [6:0] out_a_code_out,
	output logic [6:0] out_b_code_out,
	output logic out_a_load_out,
	output logic out_b_load_out,
	output logic [3:0] boost_level_out,
	output logic [1:0] power_mode_out
);
	import tcb_pkg::*;

	typedef struct packed {
		tcb_state_type st;
		logic [3:0] cnt;
		logic [11:0] sh;
		logic [7:0] addr;
		logic [3:0] bc;
		logic rd;
		logic ext;
		logic armed;
		logic sclk_p;
		logic sdata_p;
		logic oe;
		logic dout;
		logic [7:0] txb;
		logic arm_slave_id_maker_code_high;
		logic load_a;
		logic load_b;
		tcb_regs_type regs;
	} tcb_core_type;

	tcb_core_type q;
	tcb_core_type d;
	logic [SYNC_W-1:0] pins;
	logic s_sclk;
	logic s_sdata;
	logic s_io;
	logic [1:0] s_fuse;
	logic [7:0] rd_data;
	logic [12:0] frame;
	logic [3:0] sid;
	logic [7:0] cmd;
	logic rise;
	logic fall;
	logic wr_ok;
	logic rd_ok;
	logic we;
	logic [7:0] wa;
	logic [7:0] wdat;
	logic [4:0] widx;
	logic [2:0] err;
	logic any_enable;

	tcb_sync u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in({otp_fuse_in, io_supply_in, rffe_sdata_in, rffe_sclk_in}),
		.sync_out(pins)
	);

	assign s_sclk = pins[SYNC_SCLK];
	assign s_sdata = pins[SYNC_SDATA];
	assign s_io = pins[SYNC_IO];
	assign s_fuse = pins[SYNC_FUSE +: 2];

	tcb_read_mux u_mux (
		.addr_in(q.addr),
		.regs_in(q.regs),
		.fuse_in(s_fuse),
		.data_out(rd_data)
	);

	always_comb begin
		d = q;
		frame = {q.sh, s_sdata};
		sid = frame[12:9];
		cmd = frame[8:1];
		rise = s_sclk & ~q.sclk_p;
		fall = ~s_sclk & q.sclk_p;
		// broadcast and group ids address writes, reads need the own id
		wr_ok = (sid == q.regs[IDX_SLAVE_ID_MAKER_CODE_HIGH][3:0]) || (sid == BROADCAST_SID)
			|| (q.regs[IDX_GROUP_SID][3:0] != BROADCAST_SID
			&& sid == q.regs[IDX_GROUP_SID][3:0]);
		rd_ok = sid == q.regs[IDX_SLAVE_ID_MAKER_CODE_HIGH][3:0];
		we = 1'b0;
		wa = q.addr;
		wdat = 8'h00;
		err = 3'b000;
		any_enable = q.regs[IDX_ENABLE][ENA_A_POS]
			| q.regs[IDX_ENABLE][ENA_B_POS];
		d.sclk_p = s_sclk;
		d.sdata_p = s_sdata;
		d.load_a = 1'b0;
		d.load_b = 1'b0;
		if (fall) begin
			d.sh = {q.sh[10:0], s_sdata};
		end
		case (q.st)
			ST_IDLE: begin
				d.oe = 1'b0;
				d.cnt = 4'h0;
				// start: data pulses high then low while the clock is low
				if (s_sclk) begin
					d.armed = 1'b0;
				end else if (s_sdata & ~q.sdata_p) begin
					d.armed = 1'b1;
				end else if (q.armed & ~s_sdata & q.sdata_p) begin
					d.armed = 1'b0;
					d.st = ST_CMD;
				end
			end
			ST_CMD: if (fall) begin
				d.cnt = q.cnt + 4'h1;
				if (q.cnt == CMD_LAST) begin
					d.st = ST_IDLE;
					d.cnt = 4'h0;
					d.bc = 4'h0;
					d.ext = 1'b0;
					d.rd = 1'b0;
					d.addr = {3'b000, cmd[4:0]};
					if (tcb_odd_par(frame[12:1]) != frame[0]) begin
						err[ERR_CMD_PAR] = rd_ok;
					end else if (cmd[7]) begin
						we = wr_ok;
						wa = OFF_ENABLE;
						wdat = {1'b0, cmd[6:0]};
					end else if (cmd[6:5] == 2'b10) begin
						if (wr_ok) begin
							d.st = ST_DATA;
						end
					end else if (cmd[6:5] == 2'b11) begin
						d.rd = 1'b1;
						if (rd_ok) begin
							d.st = ST_TURN;
						end
					end else if (cmd[6:4] == 3'b000 || cmd[6:4] == 3'b010) begin
						d.ext = 1'b1;
						d.rd = cmd[5];
						d.bc = cmd[3:0];
						if (cmd[5] ? rd_ok : wr_ok) begin
							d.st = ST_ADDR;
						end
					end else begin
						err[ERR_CMD] = rd_ok;
					end
				end
			end
			ST_ADDR: if (fall) begin
				d.cnt = q.cnt + 4'h1;
				if (q.cnt == FRAME_LAST) begin
					d.cnt = 4'h0;
					d.addr = frame[8:1];
					d.st = q.rd ? ST_TURN : ST_DATA;
					if (tcb_odd_par({4'h0, frame[8:1]}) != frame[0]) begin
						err[ERR_DAT_PAR] = 1'b1;
						d.st = ST_IDLE;
					end
				end
			end
			ST_DATA: if (fall) begin
				d.cnt = q.cnt + 4'h1;
				if (q.cnt == FRAME_LAST) begin
					d.cnt = 4'h0;
					if (tcb_odd_par({4'h0, frame[8:1]}) != frame[0]) begin
						err[ERR_DAT_PAR] = 1'b1;
						d.st = ST_IDLE;
					end else begin
						we = 1'b1;
						wdat = frame[8:1];
						if (q.bc == 4'h0) begin
							d.st = ST_IDLE;
						end else begin
							d.bc = q.bc - 4'h1;
							d.addr = q.addr + 8'h01;
						end
					end
				end
			end
			// bus park cycle handed over by the master before read data
			ST_TURN: if (fall) begin
				d.st = ST_TX;
				d.cnt = 4'h0;
				d.txb = rd_data;
			end
			ST_TX: if (rise) begin
				d.oe = 1'b1;
				d.cnt = q.cnt + 4'h1;
				if (q.cnt < FRAME_LAST) begin
					d.dout = q.txb[3'd7 - q.cnt[2:0]];
				end else if (q.cnt == FRAME_LAST) begin
					d.dout = tcb_odd_par({4'h0, q.txb});
					if (q.bc != 4'h0) begin
						d.addr = q.addr + 8'h01;
					end
				end else if (q.bc == 4'h0) begin
					d.dout = 1'b0;
					d.st = ST_TXPARK;
				end else begin
					d.txb = rd_data;
					d.dout = rd_data[7];
					d.cnt = 4'h1;
					d.bc = q.bc - 4'h1;
				end
			end
			// drive low for half a cycle, then release the line
			ST_TXPARK: if (fall) begin
				d.oe = 1'b0;
				d.st = ST_IDLE;
			end
			default: d.st = ST_IDLE;
		endcase

		widx = tcb_index(wa);
		if (we) begin
			d.arm_slave_id_maker_code_high = 1'b0;
		end
		// unmapped addresses fall through with no effect
		if (we && widx[4]) begin
			case (widx[3:0])
				IDX_CODE_A, IDX_CODE_B: if (any_enable) begin
					d.regs[widx[3:0]] = wdat & REG_MASK[widx[3:0]];
					d.load_a = widx[3:0] == IDX_CODE_A;
					d.load_b = widx[3:0] == IDX_CODE_B;
				end
				IDX_PRODUCT: d.arm_slave_id_maker_code_high = wdat == {PRODUCT_HI, s_fuse};
				IDX_SLAVE_ID_MAKER_CODE_HIGH: if (q.arm_slave_id_maker_code_high) begin
					d.regs[IDX_SLAVE_ID_MAKER_CODE_HIGH] = wdat & REG_MASK[IDX_SLAVE_ID_MAKER_CODE_HIGH];
				end
				IDX_PMTRIG: begin
					if (wdat[SWR_POS]
						|| wdat[PM_POS +: 2] == PM_STARTUP) begin
						// the programmed slave id survives a soft reset
						d.regs = REG_RESET;
						d.regs[IDX_SLAVE_ID_MAKER_CODE_HIGH] = q.regs[IDX_SLAVE_ID_MAKER_CODE_HIGH];
					end else begin
						d.regs[IDX_PMTRIG] = wdat & REG_MASK[IDX_PMTRIG];
					end
				end
				// glide register is only reachable by an 8-bit address
				default: d.regs[widx[3:0]] = wdat & REG_MASK[widx[3:0]];
			endcase
		end
		// a new error beats a simultaneous clear from the bus
		d.regs[IDX_STATUS][2:0] = d.regs[IDX_STATUS][2:0] | err;
		if (!s_io) begin
			d.regs = REG_RESET;
			d.st = ST_IDLE;
			d.oe = 1'b0;
			d.arm_slave_id_maker_code_high = 1'b0;
			d.load_a = 1'b0;
			d.load_b = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '{st: ST_IDLE, cnt: 4'h0, sh: 12'h000, addr: 8'h00,
				bc: 4'h0, rd: 1'b0, ext: 1'b0, armed: 1'b0, sclk_p: 1'b0,
				sdata_p: 1'b0, oe: 1'b0, dout: 1'b0, txb: 8'h00,
				arm_slave_id_maker_code_high: 1'b0, load_a: 1'b0, load_b: 1'b0,
				regs: REG_RESET};
		end else begin
			q <= d;
		end
	end

	// disabling gates the output and, with both outputs off, drops code writes; overdrive timing lives downstream
	assign out_a_enable_out = q.regs[IDX_ENABLE][ENA_A_POS];
	assign out_b_enable_out = q.regs[IDX_ENABLE][ENA_B_POS];
	assign spread_enable_out = q.regs[IDX_ENABLE][ENA_SPREAD_POS];
	assign out_a_code_out = q.regs[IDX_CODE_A][6:0];
	assign out_b_code_out = q.regs[IDX_CODE_B][6:0];
	assign out_a_load_out = q.load_a;
	assign out_b_load_out = q.load_b;
	assign boost_level_out = q.regs[IDX_BOOST][3:0];
	assign power_mode_out = q.regs[IDX_PMTRIG][PM_POS +: 2];
	assign rffe_sdata_out = q.dout;
	assign rffe_sdata_oe_out = q.oe;

	property p_oe_tx;
		@(posedge clk_in) disable iff (!rst_n_in)
		rffe_sdata_oe_out |-> (q.st == ST_TX || q.st == ST_TXPARK);
	endproperty
	a_oe_tx: assert property (p_oe_tx)
		else $error("data driven outside a read");

	property p_first_bit;
		@(posedge clk_in) disable iff (!rst_n_in)
		(rise && q.st == ST_TX && q.cnt == 4'h0 && s_io)
		|=> rffe_sdata_oe_out && rffe_sdata_out == $past(q.txb[7]);
	endproperty
	a_first_bit: assert property (p_first_bit)
		else $error("first read bit is not the msb");

	property p_enable_a;
		@(posedge clk_in) disable iff (!rst_n_in)
		(we && wa == OFF_ENABLE && s_io)
		|=> out_a_enable_out == $past(wdat[ENA_A_POS]);
	endproperty
	a_enable_a: assert property (p_enable_a)
		else $error("output A enable not written");

	property p_enable_b;
		@(posedge clk_in) disable iff (!rst_n_in)
		(we && wa == OFF_ENABLE && s_io)
		|=> out_b_enable_out == $past(wdat[ENA_B_POS]);
	endproperty
	a_enable_b: assert property (p_enable_b)
		else $error("output B enable not written");

	property p_code_drop;
		@(posedge clk_in) disable iff (!rst_n_in)
		(we && wa == OFF_CODE_A && !out_a_enable_out && !out_b_enable_out)
		|=> $stable(out_a_code_out) && !out_a_load_out;
	endproperty
	a_code_drop: assert property (p_code_drop)
		else $error("code write taken while outputs disabled");

	property p_load_cause;
		@(posedge clk_in) disable iff (!rst_n_in)
		out_a_load_out |-> $past(we) && $past(wa) == OFF_CODE_A;
	endproperty
	a_load_cause: assert property (p_load_cause)
		else $error("load pulse without code write");

	property p_soft_reset;
		@(posedge clk_in) disable iff (!rst_n_in)
		(we && wa == OFF_PMTRIG && wdat[PM_POS +: 2] == PM_STARTUP)
		|=> spread_enable_out && !out_a_enable_out
			&& boost_level_out == REG_RESET[IDX_BOOST][3:0];
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("startup mode did not restore defaults");

	property p_cmd_parity;
		@(posedge clk_in) disable iff (!rst_n_in)
		(q.st == ST_CMD && fall && q.cnt == CMD_LAST && rd_ok && s_io
			&& tcb_odd_par(frame[12:1]) != frame[0])
		|=> q.st == ST_IDLE ##0 q.regs[IDX_STATUS][ERR_CMD_PAR];
	endproperty
	a_cmd_parity: assert property (p_cmd_parity)
		else $error("command parity error not recorded");

	property p_maker;
		@(posedge clk_in) disable iff (!rst_n_in)
		q.addr == OFF_MAKER_LO |-> rd_data == MAKER_CODE[7:0];
	endproperty
	a_maker: assert property (p_maker)
		else $error("maker code read wrong");

	property p_product;
		@(posedge clk_in) disable iff (!rst_n_in)
		q.addr == OFF_PRODUCT |-> rd_data == {PRODUCT_HI, s_fuse};
	endproperty
	a_product: assert property (p_product)
		else $error("product number read wrong");

	property p_reserved;
		@(posedge clk_in) disable iff (!rst_n_in)
		q.addr == OFF_ENABLE |-> (rd_data & ~REG_MASK[IDX_ENABLE]) == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved enable bits read nonzero");

	property p_glide_ext;
		@(posedge clk_in) disable iff (!rst_n_in)
		(we && wa == OFF_GLIDE) |-> q.ext;
	endproperty
	a_glide_ext: assert property (p_glide_ext)
		else $error("glide written without extended write");

	property p_io_low;
		@(posedge clk_in) disable iff (!rst_n_in)
		!s_io |=> !out_a_enable_out && !out_b_enable_out && spread_enable_out;
	endproperty
	a_io_low: assert property (p_io_low)
		else $error("low io supply kept register contents");
endmodule

// ### tcb_rffe_master.sv
// tcb_rffe_master: behavioural rffe bus master on the link pins
// assumes: slave samples on sclk falls and drives data after sclk rises
`timescale 1ns/1ps
module tcb_rffe_master (
	output logic sclk_out,
	output logic sdata_out,
	output logic sdata_oe_out,
	input wire logic sdata_in
);
	// half period in ns; raised by the bench to act as a slow master
	int half = 40;
	initial begin
		sclk_out = 1'b0;
		sdata_out = 1'b0;
		sdata_oe_out = 1'b0;
	end
	task automatic bit_out(input logic b);
		sclk_out = 1'b1;
		sdata_out = b;
		#(half);
		sclk_out = 1'b0;
		#(half);
	endtask
	// msb first then odd parity; bad flips parity on purpose
	task automatic frame(input logic [11:0] v, input int n, input logic bad);
		logic p;
		p = bad;
		for (int i = n - 1; i >= 0; i--) begin
			bit_out(v[i]);
			p = p ^ v[i];
		end
		bit_out(~p);
	endtask
	// start pulse only while sclk is low, so it cannot look like data
	task automatic start(input logic [3:0] sa, input logic [7:0] c,
		input logic bad);
		sdata_oe_out = 1'b1;
		sdata_out = 1'b1;
		#(half);
		sdata_out = 1'b0;
		#(half);
		frame({sa, c}, 12, bad);
	endtask
	// park: drive 0 while high, let go at the fall
	task automatic park();
		sclk_out = 1'b1;
		sdata_out = 1'b0;
		#(half);
		sclk_out = 1'b0;
		sdata_oe_out = 1'b0;
		#(half);
	endtask
	task automatic wr(input logic [3:0] sa, input logic [7:0] c,
		input logic [7:0] d, input logic ext, input logic [7:0] a);
		start(sa, c, 1'b0);
		if (ext) frame({4'h0, a}, 8, 1'b0);
		if (!c[7]) frame({4'h0, d}, 8, 1'b0);
		park();
	endtask
	task automatic rd(input logic [3:0] sa, input logic [7:0] c,
		input logic ext, input logic [7:0] a, output logic [7:0] d,
		output logic pe);
		logic [8:0] s;
		s = 9'h000;
		start(sa, c, 1'b0);
		if (ext) frame({4'h0, a}, 8, 1'b0);
		park();
		for (int i = 0; i < 10; i++) begin
			sclk_out = 1'b1;
			#(half);
			if (i < 9) s = {s[7:0], sdata_in};
			sclk_out = 1'b0;
			#(half);
		end
		d = s[8:1];
		pe = ~^s;
	endtask
endmodule

// ### tb_rffe_slave_register_map.sv
// tb_rffe_slave_register_map: self-checking bench of the register slave
// assumes: tcb_rffe_master drives the link; data line pulled low when idle
`timescale 1ns/1ps
module tb_rffe_slave_register_map;
	import tcb_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} tcb_tb_row_type;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic io_ok = 1'b1;
	logic [1:0] fuse = 2'h2;
	logic sclk, m_dat, m_oe, s_dat, s_oe, bus, a_en, b_en, ss_en, a_ld;
	logic [6:0] a_code;
	logic [6:0] b_code;
	logic b_ld;
	int b_loads = 0;
	logic [3:0] boost;
	logic [1:0] pmode;
	logic [7:0] d;
	logic pe;
	int num_errors = 0;
	int total_checks = 0;
	int a_loads = 0;
	localparam tcb_tb_row_type ROWS [12] = '{
		'{8'h00, 8'hFF, 8'h4C}, '{8'h01, 8'h5A, 8'h5A},
		'{8'h02, 8'hFF, 8'h7F}, '{8'h03, 8'h80, 8'h00},
		'{8'h09, 8'hFF, 8'h0C}, '{8'h10, 8'hFF, 8'h1F},
		'{8'h12, 8'hFF, 8'h0F}, '{8'h13, 8'hA3, 8'h03},
		'{8'h1B, 8'h03, 8'h03}, '{8'h1D, 8'hFF, 8'h56},
		'{8'h1E, 8'hFF, 8'hA5}, '{8'h15, 8'hFF, 8'h00}};
	always #4 clk = ~clk;
	// the slave wins when it drives; nobody driving reads as the pull-down
	assign bus = s_oe ? s_dat : (m_oe ? m_dat : 1'b0);
	always @(posedge clk) if (a_ld === 1'b1) a_loads++;
	always @(posedge clk) if (b_ld === 1'b1) b_loads++;
	tcb_rffe_master m (.sclk_out(sclk), .sdata_out(m_dat),
		.sdata_oe_out(m_oe), .sdata_in(bus));
	tcb_rffe_slave u_dut (.clk_in(clk), .rst_n_in(rst_n),
		.rffe_sclk_in(sclk), .rffe_sdata_in(bus), .rffe_sdata_out(s_dat),
		.rffe_sdata_oe_out(s_oe), .io_supply_in(io_ok), .otp_fuse_in(fuse),
		.out_a_enable_out(a_en), .out_b_enable_out(b_en),
		.spread_enable_out(ss_en),
		.out_a_code_out(a_code), .out_b_code_out(b_code),
		.out_a_load_out(a_ld),
		.out_b_load_out(b_ld), .boost_level_out(boost),
		.power_mode_out(pmode));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wreg(input logic [3:0] sa, input logic [7:0] a,
		input logic [7:0] v);
		m.wr(sa, {3'h2, a[4:0]}, v, 1'b0, 8'h00);
		tick(6);
	endtask
	task automatic rdc(input string w, input logic [3:0] sa,
		input logic [7:0] a, input logic [7:0] e);
		m.rd(sa, {3'h3, a[4:0]}, 1'b0, 8'h00, d, pe);
		chk(w, e, d);
		chk("read parity", 8'h00, {7'h00, pe});
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#600_000;
		num_errors++;
		end_of_test();
	end
	initial begin
		tick(16);
		rst_n = 1'b1;
		tick(6);
		foreach (ROWS[i]) begin
			wreg(4'h7, ROWS[i].a, ROWS[i].d);
			rdc("row read", 4'h7, ROWS[i].a, ROWS[i].e);
		end
		$display("register rows done");
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(6);
		chk("spread", 8'h01, {7'h00, ss_en});
		chk("enable a", 8'h00, {7'h00, a_en});
		chk("enable b", 8'h00, {7'h00, b_en});
		chk("boost", 8'h0B, {4'h0, boost});
		rdc("enable reset", 4'h7, 8'h00, 8'h40);
		rdc("steps reset", 4'h7, 8'h12, 8'h05);
		rdc("slave_id_maker_code_high reg", 4'h7, 8'h1F, 8'h27);
		$display("reset test done");
		wreg(4'h7, 8'h00, 8'h08);
		chk("enable a", 8'h01, {7'h00, a_en});
		chk("spread off", 8'h00, {7'h00, ss_en});
		wreg(4'h7, 8'h00, 8'h00);
		a_loads = 0;
		wreg(4'h7, 8'h02, 8'h11);
		chk("gated loads", 8'h00, 8'(a_loads));
		rdc("gated code", 4'h7, 8'h02, 8'h00);
		wreg(4'h7, 8'h00, 8'h04);
		wreg(4'h7, 8'h02, 8'h15);
		chk("code a", 8'h15, {1'b0, a_code});
		chk("loads", 8'h01, 8'(a_loads));
		chk("enable b on", 8'h01, {7'h00, b_en});
		b_loads = 0;
		wreg(4'h7, 8'h03, 8'hAA);
		chk("code b", 8'h2A, {1'b0, b_code});
		chk("loads b", 8'h01, 8'(b_loads));
		$display("enable gate test done");
		wreg(4'h7, 8'h10, 8'h03);
		wreg(4'h7, 8'h1C, 8'h20);
		rdc("soft reset", 4'h7, 8'h10, 8'h1B);
		chk("spread", 8'h01, {7'h00, ss_en});
		wreg(4'h7, 8'h10, 8'h03);
		wreg(4'h7, 8'h1C, 8'h40);
		rdc("startup reset", 4'h7, 8'h10, 8'h1B);
		chk("power mode", 8'h00, {6'h00, pmode});
		$display("soft reset test done");
		m.start(4'h7, 8'h50, 1'b1);
		m.frame(12'h033, 8, 1'b0);
		m.park();
		tick(6);
		rdc("status", 4'h7, 8'h1A, 8'h01);
		wreg(4'h7, 8'h1A, 8'h00);
		rdc("status clear", 4'h7, 8'h1A, 8'h00);
		m.wr(4'h7, 8'h00, 8'h55, 1'b1, 8'h2C);
		m.rd(4'h7, 8'h20, 1'b1, 8'h2C, d, pe);
		chk("glide", 8'h55, d);
		m.wr(4'h7, 8'hCC, 8'h00, 1'b0, 8'h00);
		rdc("reg0 write", 4'h7, 8'h00, 8'h4C);
		wreg(4'h7, 8'h1B, 8'h03);
		wreg(4'h3, 8'h10, 8'h02);
		rdc("group write", 4'h7, 8'h10, 8'h12);
		$display("protocol test done");
		io_ok = 1'b0;
		tick(8);
		io_ok = 1'b1;
		tick(8);
		rdc("supply loss", 4'h7, 8'h10, 8'h1B);
		rdc("group lost", 4'h7, 8'h1B, 8'h00);
		wreg(4'h7, 8'h1D, 8'h56);
		wreg(4'h7, 8'h1F, 8'h05);
		m.half = 200;
		rdc("new slave_id_maker_code_high", 4'h5, 8'h1F, 8'h25);
		rdc("product", 4'h5, 8'h1D, 8'h56);
		$display("supply and slave_id_maker_code_high test done");
		end_of_test();
	end
endmodule
